//--- common/plfmu_cfg.svh
/*
 * constants for the predicate logic and fault mask unit: widths, opcode
 * codes, apb register offsets and reset values.
 * assumes inclusion by bare name from design files.
 */
`ifndef PLFMU_CFG_SVH
`define PLFMU_CFG_SVH

// --------------------------------------------------------------------------
// widths
// --------------------------------------------------------------------------
`define PLFMU_PW          16
`define PLFMU_PREGS       16
`define PLFMU_RIDX_W      4
`define PLFMU_OP_W        4

// --------------------------------------------------------------------------
// operation codes
// --------------------------------------------------------------------------
`define PLFMU_OP_NOP            4'h0
`define PLFMU_OP_NOT            4'h1
`define PLFMU_OP_NOT_FLAGS      4'h2
`define PLFMU_OP_ORN            4'h3
`define PLFMU_OP_ORN_FLAGS      4'h4
`define PLFMU_OP_OR             4'h5
`define PLFMU_OP_OR_FLAGS       4'h6
`define PLFMU_OP_TEST           4'h7
`define PLFMU_OP_MRD            4'h8
`define PLFMU_OP_MRD_PRED       4'h9
`define PLFMU_OP_MRD_FLAGS      4'hA
`define PLFMU_OP_MINIT          4'hB
`define PLFMU_OP_MWRITE         4'hC

// --------------------------------------------------------------------------
// apb map
// --------------------------------------------------------------------------
`define PLFMU_A_CTRL      12'h000
`define PLFMU_A_MASK      12'h004
`define PLFMU_A_FLAGS     12'h008
`define PLFMU_A_COUNT     12'h00C
`define PLFMU_CTRL_INIT   0
`define PLFMU_MASK_RST    16'hFFFF
`define PLFMU_ZERO_PRED   16'h0000
`define PLFMU_ONE_CNT     16'h0001

`endif

//--- common/plfmu_pkg.sv
/*
 * types shared by the predicate logic and fault mask unit.
 * assumes plfmu_cfg.svh is on the include path.
 */
`include "plfmu_cfg.svh"
package plfmu_pkg;
    typedef logic [`PLFMU_PW-1:0]     plfmu_pred_t;
    typedef logic [`PLFMU_RIDX_W-1:0] plfmu_ridx_t;
    // flag order n z c v
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } plfmu_flags_s;
endpackage

//--- src/plfmu_pregfile.sv
/*
 * predicate register file: two registered read ports, one write port.
 * assumes a single clock and async active-low reset.
 */
`timescale 1ns/1ns
`include "plfmu_cfg.svh"
module plfmu_pregfile (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    // write port
    input  wire logic                 wr_en,
    input  wire plfmu_pkg::plfmu_ridx_t wr_idx,
    input  wire plfmu_pkg::plfmu_pred_t wr_data,
    // read ports
    input  wire plfmu_pkg::plfmu_ridx_t rd_a_idx,
    input  wire plfmu_pkg::plfmu_ridx_t rd_b_idx,
    output plfmu_pkg::plfmu_pred_t    rd_a_data,
    output plfmu_pkg::plfmu_pred_t    rd_b_data
);
    typedef struct packed {
        plfmu_pkg::plfmu_pred_t [`PLFMU_PREGS-1:0] mem;
        plfmu_pkg::plfmu_pred_t                     a;
        plfmu_pkg::plfmu_pred_t                     b;
    } plfmu_rf_s;

    plfmu_rf_s st_reg;
    plfmu_rf_s st_next;

    // read before write: a same-cycle write shows on the next read
    always_comb begin
        st_next   = st_reg;
        st_next.a = st_reg.mem[rd_a_idx];
        st_next.b = st_reg.mem[rd_b_idx];
        if (wr_en) begin
            st_next.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_a_data = st_reg.a;
    assign rd_b_data = st_reg.b;
endmodule

//--- src/plfmu_top.sv
/*
 * predicate logic and fault mask unit: executes predicate logic ops and
 * fault mask ops from the issue stage; apb gives software a view.
 * assumes the issue stage holds an op until op_ready and keeps
 * governing predicates canonical.
 */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "plfmu_cfg.svh"

module plfmu_top (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    // issue port
    input  wire logic                   op_valid,
    output logic                        op_ready,
    input  wire logic [`PLFMU_OP_W-1:0] op_code,
    input  wire plfmu_pkg::plfmu_ridx_t op_dst,
    input  wire plfmu_pkg::plfmu_ridx_t op_src_a,
    input  wire plfmu_pkg::plfmu_ridx_t op_src_b,
    input  wire plfmu_pkg::plfmu_ridx_t op_gov,
    // result port
    output logic                        res_valid,
    output plfmu_pkg::plfmu_pred_t      res_pred,
    output logic                        res_pred_wr,
    output plfmu_pkg::plfmu_flags_s     res_flags,
    output logic                        res_flags_wr,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr
);
    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    typedef enum logic [0:0] { PLFMU_IDLE, PLFMU_EXEC } plfmu_state_e;

    // rv, rpw and rfw are one-cycle pulses; rp holds until the next op
    // completes and rf until the next flag op, so the issue stage may look late
    typedef struct packed {
        plfmu_state_e             state;
        logic [`PLFMU_OP_W-1:0]   op;
        plfmu_pkg::plfmu_ridx_t   dst;
        plfmu_pkg::plfmu_pred_t   mask;
        plfmu_pkg::plfmu_flags_s  nzcv;
        logic                     rv;
        plfmu_pkg::plfmu_pred_t   rp;
        logic                     rpw;
        plfmu_pkg::plfmu_flags_s  rf;
        logic                     rfw;
        logic                     ctrl_hold;
        logic [15:0]              op_count;
        logic [31:0]              prdata;
        logic                     pslverr;
    } plfmu_top_s;

    plfmu_top_s st_reg;
    plfmu_top_s st_next;

    plfmu_pkg::plfmu_pred_t rf_a;
    plfmu_pkg::plfmu_pred_t rf_b;
    logic                   rf_wr;
    plfmu_pkg::plfmu_pred_t rf_wdata;
    plfmu_pkg::plfmu_ridx_t rf_a_idx;
    logic                   apb_acc;

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    // n from first element, z if none true, c if last element false
    function automatic plfmu_pkg::plfmu_flags_s pred_flags(
        input plfmu_pkg::plfmu_pred_t r);
        plfmu_pkg::plfmu_flags_s f;
        f.n = r[0];
        f.z = (r == `PLFMU_ZERO_PRED);
        f.c = ~r[`PLFMU_PW-1];
        f.v = 1'b0;
        return f;
    endfunction

    // ops whose result feeds the condition flags
    function automatic logic is_flag_op(input logic [`PLFMU_OP_W-1:0] o);
        logic f;
        case (o)
            `PLFMU_OP_NOT_FLAGS,
            `PLFMU_OP_ORN_FLAGS,
            `PLFMU_OP_OR_FLAGS,
            `PLFMU_OP_TEST,
            `PLFMU_OP_MRD_FLAGS: f = 1'b1;
            default:             f = 1'b0;
        endcase
        return f;
    endfunction

    // ops whose result lands in the destination predicate register;
    // unknown codes write nothing so a bad decode cannot corrupt state
    function automatic logic writes_pred(input logic [`PLFMU_OP_W-1:0] o);
        logic w;
        case (o)
            `PLFMU_OP_NOT,
            `PLFMU_OP_NOT_FLAGS,
            `PLFMU_OP_ORN,
            `PLFMU_OP_ORN_FLAGS,
            `PLFMU_OP_OR,
            `PLFMU_OP_OR_FLAGS,
            `PLFMU_OP_MRD,
            `PLFMU_OP_MRD_PRED,
            `PLFMU_OP_MRD_FLAGS: w = 1'b1;
            default:             w = 1'b0;
        endcase
        return w;
    endfunction

    // predicated mask reads take the governing predicate on port a
    function automatic logic uses_gov(input logic [`PLFMU_OP_W-1:0] o);
        return (o == `PLFMU_OP_MRD_PRED) || (o == `PLFMU_OP_MRD_FLAGS);
    endfunction

    // one decode of the apb map for the error path
    function automatic logic apb_mapped(input logic [11:0] a);
        logic m;
        if (a == `PLFMU_A_CTRL) begin
            m = 1'b1;
        end else if (a == `PLFMU_A_MASK) begin
            m = 1'b1;
        end else if (a == `PLFMU_A_FLAGS) begin
            m = 1'b1;
        end else if (a == `PLFMU_A_COUNT) begin
            m = 1'b1;
        end else begin
            m = 1'b0;
        end
        return m;
    endfunction

    // the issue fields only matter in the cycle an op is taken; the
    // file latches its read every cycle, so an idle read is harmless
    assign rf_a_idx = uses_gov(op_code) ? op_gov : op_src_a;

    plfmu_pregfile u_rf (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .wr_en     (rf_wr),
        .wr_idx    (st_reg.dst),
        .wr_data   (rf_wdata),
        .rd_a_idx  (rf_a_idx),
        .rd_b_idx  (op_src_b),
        .rd_a_data (rf_a),
        .rd_b_data (rf_b)
    );

    assign apb_acc = psel & penable;

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    // two-cycle op: operands are read a cycle before the result forms
    always_comb begin
        plfmu_pkg::plfmu_pred_t r;
        r        = `PLFMU_ZERO_PRED;
        st_next  = st_reg;
        st_next.rv  = 1'b0;
        st_next.rpw = 1'b0;
        st_next.rfw = 1'b0;
        rf_wr    = 1'b0;
        rf_wdata = `PLFMU_ZERO_PRED;
        case (st_reg.state)
            PLFMU_IDLE: begin
                // ctrl_hold stalls the take exactly as op_ready shows it
                if (op_valid && !st_reg.ctrl_hold) begin
                    st_next.op    = op_code;
                    st_next.dst   = op_dst;
                    st_next.state = PLFMU_EXEC;
                end
            end
            PLFMU_EXEC: begin
                st_next.state = PLFMU_IDLE;
                case (st_reg.op)
                    // plain logic on one or two operand predicates
                    `PLFMU_OP_NOT, `PLFMU_OP_NOT_FLAGS: begin
                        r = ~rf_a;
                    end
                    `PLFMU_OP_ORN, `PLFMU_OP_ORN_FLAGS: begin
                        r = rf_a | ~rf_b;
                    end
                    `PLFMU_OP_OR, `PLFMU_OP_OR_FLAGS: begin
                        r = rf_a | rf_b;
                    end
                    // test only feeds the flags, the bus below reads zero
                    `PLFMU_OP_TEST: begin
                        r = rf_a;
                    end
                    // mask reads, plain and under a governing predicate
                    `PLFMU_OP_MRD: begin
                        r = st_reg.mask;
                    end
                    `PLFMU_OP_MRD_PRED, `PLFMU_OP_MRD_FLAGS: begin
                        r = st_reg.mask & rf_a;
                    end
                    // mask updates; a software write in this cycle loses
                    `PLFMU_OP_MINIT: begin
                        st_next.mask = `PLFMU_MASK_RST;
                    end
                    `PLFMU_OP_MWRITE: begin
                        st_next.mask = rf_a;
                    end
                    default: begin
                        r = `PLFMU_ZERO_PRED;
                    end
                endcase
                st_next.rv  = 1'b1;
                // test and mask updates write no predicate register
                st_next.rpw = writes_pred(st_reg.op);
                // the result bus reads zero whenever nothing is written
                st_next.rp  = st_next.rpw ? r : `PLFMU_ZERO_PRED;
                rf_wr    = st_next.rpw;
                rf_wdata = r;
                if (is_flag_op(st_reg.op)) begin
                    st_next.rf   = pred_flags(r);
                    st_next.rfw  = 1'b1;
                    st_next.nzcv = pred_flags(r);
                end
                st_next.op_count = st_reg.op_count + `PLFMU_ONE_CNT;
            end
            default: st_next.state = PLFMU_IDLE;
        endcase

        // apb: zero-wait, registered read data
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            // read word is latched at setup so it stands through access
            st_next.prdata  = 32'h0000_0000;
            st_next.pslverr = !apb_mapped(paddr);
            if (paddr == `PLFMU_A_CTRL) begin
                st_next.prdata[0] = st_reg.ctrl_hold;
            end else if (paddr == `PLFMU_A_MASK) begin
                st_next.prdata[`PLFMU_PW-1:0] = st_reg.mask;
            end else if (paddr == `PLFMU_A_FLAGS) begin
                st_next.prdata[3:0] = st_reg.nzcv;
            end else if (paddr == `PLFMU_A_COUNT) begin
                st_next.prdata[15:0] = st_reg.op_count;
            end
        end else if (apb_acc) begin
            st_next.pslverr = st_reg.pslverr;
            // a same-cycle unit update of the mask wins over software
            if (pwrite && paddr == `PLFMU_A_CTRL) begin
                st_next.ctrl_hold = pwdata[0];
            end else if (pwrite && paddr == `PLFMU_A_MASK &&
                         st_reg.state == PLFMU_IDLE) begin
                st_next.mask = pwdata[`PLFMU_PW-1:0];
            end
        end
    end

    // ----------------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------------
    // reset leaves the mask all true: a first read finds every element
    // loaded, the same as a freshly initialised mask
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg           <= '0;
            st_reg.state     <= PLFMU_IDLE;
            st_reg.mask      <= `PLFMU_MASK_RST;
            st_reg.ctrl_hold <= 1'(`PLFMU_CTRL_INIT);
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    // issue handshake is combinational: a held op is taken on the next edge
    assign op_ready     = (st_reg.state == PLFMU_IDLE) && !st_reg.ctrl_hold;

    // result port straight from flops, so the issue stage sees clean pulses
    assign res_valid    = st_reg.rv;
    assign res_pred     = st_reg.rp;
    assign res_pred_wr  = st_reg.rpw;
    assign res_flags    = st_reg.rf;
    assign res_flags_wr = st_reg.rfw;

    // apb never stretches; the error only shows in the access phase
    assign pready       = 1'b1;
    assign prdata       = st_reg.prdata;
    assign pslverr      = st_reg.pslverr & apb_acc;
endmodule

//--- tb/plfmu_chk.sv
/* checker for the predicate unit: issue timing, result flags, apb.
   assumes a bind onto plfmu_top from the bench top file. */
`timescale 1ns/1ns
`include "plfmu_cfg.svh"
module plfmu_chk (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    resetn,
    // issue and result
    input wire logic                    op_valid,
    input wire logic                    op_ready,
    input wire logic [`PLFMU_OP_W-1:0]  op_code,
    input wire logic                    res_valid,
    input wire plfmu_pkg::plfmu_pred_t  res_pred,
    input wire logic                    res_pred_wr,
    input wire plfmu_pkg::plfmu_flags_s res_flags,
    input wire logic                    res_flags_wr,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pready,
    input wire logic                    pslverr
);
    logic [`PLFMU_OP_W-1:0] code_reg;
    logic                   fop;
    logic                   pop;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // code of the op in flight; only one can be in flight at a time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) code_reg <= '0;
        else if (op_valid && op_ready) code_reg <= op_code;
    end
    // ops other than test that set flags, ops that write a predicate
    assign fop = code_reg inside {4'h2, 4'h4, 4'h6, 4'hA};
    assign pop = code_reg inside {[4'h1:4'h6], [4'h8:4'hA]};
    sequence s_take; op_valid && op_ready; endsequence
    sequence s_answer; !res_valid ##1 res_valid ##1 !res_valid; endsequence
    property p_latency; s_take |=> s_answer; endproperty
    property p_busy; s_take |=> !op_ready; endproperty
    property p_cause; res_valid |-> $past(op_valid && op_ready, 2);
    endproperty
    property p_flag_calc; res_valid && fop |-> res_flags_wr &&
        res_flags == {res_pred[0], res_pred == 16'h0000, !res_pred[15],
        1'b0}; endproperty
    property p_v_zero; res_flags_wr |-> !res_flags.v; endproperty
    property p_noflag; res_valid && !fop && code_reg != 4'h7
        |-> !res_flags_wr; endproperty
    property p_test; res_valid && code_reg == 4'h7 |-> res_flags_wr &&
        !res_pred_wr && res_pred == 16'h0000; endproperty
    property p_mask_only; res_valid && code_reg inside {4'hB, 4'hC}
        |-> !res_pred_wr && !res_flags_wr; endproperty
    property p_predwr; res_valid && pop |-> res_pred_wr; endproperty
    property p_apb; psel && penable |-> pready; endproperty
    property p_err; pslverr |-> psel && penable; endproperty
    a_latency: assert property (p_latency) else $error("bad latency");
    a_busy: assert property (p_busy) else $error("ready while busy");
    a_cause: assert property (p_cause) else $error("result without op");
    a_flag_calc: assert property (p_flag_calc)
        else $error("flags wrong");
    a_v_zero: assert property (p_v_zero)
        else $error("v set");
    a_noflag: assert property (p_noflag)
        else $error("flags written");
    a_test: assert property (p_test)
        else $error("test wrote predicate");
    a_mask_only: assert property (p_mask_only)
        else $error("mask op wrote result");
    a_predwr: assert property (p_predwr)
        else $error("no predicate write");
    a_apb: assert property (p_apb) else $error("pready low");
    a_err: assert property (p_err) else $error("pslverr outside access");
endmodule

//--- tb/plfmu_issue.sv
/* issue stage model: presents one op and holds it until op_ready.
   assumes the bench calls send and watches the result port. */
`timescale 1ns/1ns
`include "plfmu_cfg.svh"
module plfmu_issue (
    // clock
    input wire logic                   clk_sys,
    // issue port
    input wire logic                   op_ready,
    output logic                       op_valid,
    output logic [`PLFMU_OP_W-1:0]     op_code,
    output plfmu_pkg::plfmu_ridx_t     op_dst,
    output plfmu_pkg::plfmu_ridx_t     op_src_a,
    output plfmu_pkg::plfmu_ridx_t     op_src_b,
    output plfmu_pkg::plfmu_ridx_t     op_gov
);
    initial begin
        op_valid = 1'b0;
        {op_code, op_dst, op_src_a, op_src_b, op_gov} = '0;
    end
    // any 1-bit-element predicate is canonical, so gov is free
    task automatic send(input logic [19:0] f, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        {op_code, op_dst, op_src_a, op_src_b, op_gov} <= f;
        for (n = 0; n < 16 && !ok; n++) begin
            @(negedge clk_sys);
            ok = op_ready;
        end
        @(posedge clk_sys);
        op_valid <= 1'b0;
        // released fields flip so stale values are never trusted
        {op_code, op_dst, op_src_a, op_src_b, op_gov} <= ~f;
    endtask
endmodule

//--- tb/plfmu_top_tb.sv
/* bench for the predicate unit: ops through the issue model, apb view.
   assumes the checker and issue model are compiled alongside. */
`timescale 1ns/1ns
`include "plfmu_cfg.svh"
module plfmu_top_tb;
    logic        clk_sys, resetn, psel, penable, pwrite, op_valid;
    logic        op_ready, res_valid, res_pred_wr, res_flags_wr;
    logic        pready, pslverr, e;
    logic [3:0]  op_code, op_dst, op_src_a, op_src_b, op_gov;
    logic [11:0] paddr;
    logic [15:0] res_pred;
    logic [31:0] pwdata, prdata, r;
    plfmu_pkg::plfmu_flags_s res_flags;
    int          n_mismatch, n_compared, n_ops;
    plfmu_top u_plfmu_top (
        .clk_sys      (clk_sys),
        .resetn       (resetn),
        .op_valid     (op_valid),
        .op_ready     (op_ready),
        .op_code      (op_code),
        .op_dst       (op_dst),
        .op_src_a     (op_src_a),
        .op_src_b     (op_src_b),
        .op_gov       (op_gov),
        .res_valid    (res_valid),
        .res_pred     (res_pred),
        .res_pred_wr  (res_pred_wr),
        .res_flags    (res_flags),
        .res_flags_wr (res_flags_wr),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .pready       (pready),
        .prdata       (prdata),
        .pslverr      (pslverr)
    );
    plfmu_issue u_plfmu_issue (
        .clk_sys      (clk_sys),
        .op_ready     (op_ready),
        .op_valid     (op_valid),
        .op_code      (op_code),
        .op_dst       (op_dst),
        .op_src_a     (op_src_a),
        .op_src_b     (op_src_b),
        .op_gov       (op_gov)
    );
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [3:0] fl(input logic [15:0] p);
        return {p[0], p == 16'h0000, ~p[15], 1'b0};
    endfunction
    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, x, input string s);
        n_compared++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask
    task automatic lost();
        n_mismatch++;
        finish_test();
    endtask
    // one apb transfer, answer taken while pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 16) lost();
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // issue one op and compare its result pulse
    task automatic op(input logic [19:0] f, input logic [15:0] ep,
                      input logic pw, fw, input logic [3:0] ef);
        int n;
        bit ok;
        u_plfmu_issue.send(f, ok);
        if (!ok) lost();
        n_ops++;
        for (n = 0; n < 8 && res_valid !== 1'b1; n++) @(negedge clk_sys);
        if (n == 8) lost();
        chk(res_pred, ep, "result");
        chk({res_pred_wr, res_flags_wr}, {pw, fw}, "write strobes");
        if (fw) chk(res_flags, ef, "flags");
    endtask
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {n_mismatch, n_compared, n_ops} = '0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        op(20'h83000, 16'hFFFF, 1, 0, 0);
        apb(1, `PLFMU_A_MASK, 32'hA5C3);
        op(20'h83000, 16'hA5C3, 1, 0, 0);
        apb(1, `PLFMU_A_MASK, 32'h0F0F);
        op(20'h84000, 16'h0F0F, 1, 0, 0);
        op(20'h11000, 16'hFFFF, 1, 0, 0);
        op(20'h55340, 16'hAFCF, 1, 0, 0);
        op(20'h66340, 16'hAFCF, 1, 1, fl(16'hAFCF));
        op(20'h38340, 16'hF5F3, 1, 0, 0);
        op(20'h49010, 16'h0000, 1, 1, fl(16'h0000));
        op(20'h27300, 16'h5A3C, 1, 1, fl(16'h5A3C));
        op(20'h70700, 16'h0000, 0, 1, fl(16'h5A3C));
        op(20'h5A000, 16'h0000, 1, 0, 0);
        op(20'hC0300, 16'h0000, 0, 0, 0);
        apb(0, `PLFMU_A_MASK, 0);
        chk(r[15:0], 16'hA5C3, "mask after write");
        op(20'h9B004, 16'h0503, 1, 0, 0);
        op(20'hAC004, 16'h0503, 1, 1, fl(16'h0503));
        op(20'hB0000, 16'h0000, 0, 0, 0);
        apb(0, `PLFMU_A_MASK, 0);
        chk(r[15:0], 16'hFFFF, "mask after init");
        apb(0, `PLFMU_A_FLAGS, 0);
        chk(r[3:0], fl(16'h0503), "flags register");
        apb(0, `PLFMU_A_COUNT, 0);
        chk(r, n_ops, "op count");
        apb(0, 12'h010, 0);
        chk(e, 1'b1, "unmapped error");
        apb(1, `PLFMU_A_CTRL, 32'h1);
        @(negedge clk_sys);
        chk(op_ready, 1'b0, "hold stalls issue");
        apb(1, `PLFMU_A_CTRL, 32'h0);
        op(20'h8D000, 16'hFFFF, 1, 0, 0);
        finish_test();
    end
endmodule
bind plfmu_top plfmu_chk u_plfmu_chk (.clk_sys, .resetn, .op_valid,
    .op_ready, .op_code, .res_valid, .res_pred, .res_pred_wr, .res_flags,
    .res_flags_wr, .psel, .penable, .pready, .pslverr);
